/* inc/fcp_map.svh */
// Constants for the flash command protection host controller.
// Assumes a 25 MHz CLK; all counts are whole cycles of that clock.
`ifndef FCP_MAP_SVH
`define FCP_MAP_SVH

`define FCP_AW              21
`define FCP_DW              16
`define FCP_CNT_W           5
`define FCP_STEP_W          4

`define FCP_CLK_NS          40
`define FCP_T_GLITCH_NS     3
`define FCP_T_WP_NS         50
`define FCP_T_ACC_NS        100
`define FCP_T_TURN_NS       40
`define FCP_T_HWRST_NS      500

// Least times round up, never below one cycle
`define FCP_CEIL(ns)        (((ns) + `FCP_CLK_NS - 1) / `FCP_CLK_NS)
`define FCP_MAX1(x)         (((x) < 1) ? 1 : (x))
`define FCP_GLITCH_CYC      `FCP_MAX1(`FCP_CEIL(`FCP_T_GLITCH_NS))
`define FCP_WP_CYC          `FCP_MAX1(`FCP_CEIL(`FCP_T_WP_NS))
`define FCP_STROBE_CYC      ((`FCP_WP_CYC > `FCP_GLITCH_CYC) ? \
                             `FCP_WP_CYC : (`FCP_GLITCH_CYC + 1))
`define FCP_SYNC_LAT        4
`define FCP_RD_CYC          (`FCP_MAX1(`FCP_CEIL(`FCP_T_ACC_NS)) + \
                             `FCP_SYNC_LAT)
`define FCP_TURN_CYC        `FCP_MAX1(`FCP_CEIL(`FCP_T_TURN_NS))
`define FCP_HWRST_CYC       `FCP_MAX1(`FCP_CEIL(`FCP_T_HWRST_NS))
`define FCP_POLL_MAX        5'h1f

`define FCP_STEP_CMD        4'h3

`define FCP_UNLOCK_ADDR1    21'h000555
`define FCP_UNLOCK_ADDR2    21'h0002aa
`define FCP_CMD_UNLOCK1     16'h00aa
`define FCP_CMD_UNLOCK2     16'h0055
`define FCP_CMD_RESET       16'h00f0
`define FCP_CMD_ID_ENTRY    16'h0090

`define FCP_ID_BITS_MASK    21'h000043
`define FCP_ID_BITS_PROT    21'h000002
`define FCP_PROT_CODE       8'h01
`define FCP_BLOCK_FLIP      21'h100000
`define FCP_TOGGLE_BIT      6

`endif

/* inc/fcp_pkg.sv */
// Types shared by the flash command protection host controller.
// Assumes fcp_map.svh is on the include path.
`include "fcp_map.svh"

package fcp_pkg;

  typedef enum logic [2:0] {
    FCP_OP_RESET_SEQ,
    FCP_OP_CMD_WRITE,
    FCP_OP_FLASH_READ,
    FCP_OP_PROTECT_CHECK,
    FCP_OP_TOGGLE_POLL,
    FCP_OP_SRAM_WRITE,
    FCP_OP_SRAM_READ,
    FCP_OP_HW_RESET
  } fcp_op_e;

  typedef enum logic [1:0] {
    FCP_POLL_PROGRAM,
    FCP_POLL_BLOCK_ERASE,
    FCP_POLL_CHIP_ERASE,
    FCP_POLL_SUSPEND
  } fcp_poll_e;

  typedef enum logic [1:0] {
    FCP_ACC_NONE,
    FCP_ACC_WRITE,
    FCP_ACC_READ
  } fcp_acc_e;

  typedef enum logic [2:0] {
    FCP_ST_IDLE,
    FCP_ST_NEXT,
    FCP_ST_WSETUP,
    FCP_ST_WSTROBE,
    FCP_ST_WHOLD,
    FCP_ST_RSTROBE,
    FCP_ST_TURN,
    FCP_ST_HWRST
  } fcp_state_e;

  typedef struct packed {
    fcp_op_e                 op;
    fcp_poll_e               poll_kind;
    logic [`FCP_AW-1:0]      addr;
    logic [`FCP_DW-1:0]      data;
  } fcp_req_s;

  typedef struct packed {
    logic [`FCP_DW-1:0]      data;
    logic                    is_protected;
    logic                    err_lockout;
    logic                    err_timeout;
  } fcp_rsp_s;

  typedef struct packed {
    logic [`FCP_AW-1:0]      addr;
    logic [`FCP_DW-1:0]      dq_out;
    logic                    dq_oe;
    logic                    flash_chip_select_n;
    logic                    output_enable_n;
    logic                    write_enable_n;
    logic                    sram_select_low_n;
    logic                    sram_select_high;
    logic                    reset_n;
  } fcp_pin_s;

  typedef struct packed {
    fcp_acc_e                kind;
    logic                    sram;
    logic [`FCP_AW-1:0]      addr;
    logic [`FCP_DW-1:0]      data;
  } fcp_acc_s;

endpackage

/* verilog/fcp_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to CLK; output changes once the second
// and third stages agree.
`timescale 1ns/1ps

module fcp_sync #(
  parameter int W = 1
) (
  input  wire logic         CLK,
  input  wire logic         SRST,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  import fcp_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } fcp_sync_s;

  fcp_sync_s    sy_reg;
  fcp_sync_s    sy_next;
  logic [W-1:0] agree;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_agree
      assign agree[i] = sy_reg.s2[i] ~^ sy_reg.s3[i];
    end
  endgenerate

  always_comb begin
    sy_next    = sy_reg;
    sy_next.s1 = D;
    sy_next.s2 = sy_reg.s1;
    sy_next.s3 = sy_reg.s2;
    sy_next.q  = (agree & sy_reg.s3) | (~agree & sy_reg.q);
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sy_reg <= '0;
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign Q = sy_reg.q;

endmodule

/* verilog/fcp_host.sv */
// Host-side controller that drives a flash/SRAM package over its pins.
// Assumes the package pins are wired straight to PIN, DQ_IN, READY_BUSY_OUT
// and SUPPLY_LOCKOUT_LEVEL, and that a user issues one request at a time.
// What this block does
// - Host clears the command register by reset before entering commands.
// - Reset sequence AAH, 55H, F0H returns the device to array read.
// - Host holds write strobe high through every read cycle.
// - Host never drives data while the device may still drive it.
// - Protect check reads block with A6,A1,A0 = 0,1,0; 01H means protected.
// - Poll address depends on program, erase, chip erase or suspend.
`timescale 1ns/1ps
`include "fcp_map.svh"

module fcp_host (
  input  wire logic                 CLK,
  input  wire logic                 SRST,
  input  wire logic                 REQ_VALID,
  output logic                      REQ_READY,
  input  wire fcp_pkg::fcp_req_s    REQ,
  output logic                      RSP_VALID,
  output fcp_pkg::fcp_rsp_s         RSP,
  output logic                      LOST_OP,
  output fcp_pkg::fcp_pin_s         PIN,
  input  wire logic [`FCP_DW-1:0]   DQ_IN,
  input  wire logic                 READY_BUSY_OUT,
  input  wire logic                 SUPPLY_LOCKOUT_LEVEL
);
  import fcp_pkg::*;

  typedef struct packed {
    fcp_state_e              st;
    fcp_op_e                 op;
    logic [`FCP_STEP_W-1:0]  step;
    logic [`FCP_CNT_W-1:0]   cnt;
    logic [`FCP_CNT_W-1:0]   polls;
    logic [`FCP_AW-1:0]      addr;
    logic [`FCP_DW-1:0]      data;
    logic [`FCP_DW-1:0]      rd_prev;
    logic [`FCP_DW-1:0]      rd_data;
    logic                    need_reset;
    logic                    lost;
    logic                    rsp_valid;
    fcp_rsp_s                rsp;
    fcp_pin_s                pin;
  } fcp_reg_s;

  fcp_reg_s                  h_reg;
  fcp_reg_s                  h_next;
  fcp_acc_s                  acc;
  fcp_acc_s                  acc_n;
  logic [`FCP_DW+1:0]        sync_q;
  logic [`FCP_DW-1:0]        dq_s;
  logic                      rb_s;
  logic                      lock_s;

  fcp_sync #(
    .W (`FCP_DW + 2)
  ) u_sync (
    .CLK  (CLK),
    .SRST (SRST),
    .D    ({SUPPLY_LOCKOUT_LEVEL, READY_BUSY_OUT, DQ_IN}),
    .Q    (sync_q)
  );

  assign dq_s   = sync_q[`FCP_DW-1:0];
  assign rb_s   = sync_q[`FCP_DW];
  assign lock_s = sync_q[`FCP_DW+1];

  // Bus access for a given step of an operation
  function automatic fcp_acc_s fcp_access(
    input fcp_op_e                op,
    input logic [`FCP_STEP_W-1:0] step,
    input logic [`FCP_AW-1:0]     addr,
    input logic [`FCP_DW-1:0]     data
  );
    fcp_acc_s a;
    a = '{kind: FCP_ACC_NONE, sram: 1'b0, addr: addr, data: data};
    unique case (step)
      4'h0, 4'h7: a = '{FCP_ACC_WRITE, 1'b0, `FCP_UNLOCK_ADDR1,
                        `FCP_CMD_UNLOCK1};
      4'h1, 4'h8: a = '{FCP_ACC_WRITE, 1'b0, `FCP_UNLOCK_ADDR2,
                        `FCP_CMD_UNLOCK2};
      4'h2, 4'h9: a = '{FCP_ACC_WRITE, 1'b0, `FCP_UNLOCK_ADDR1,
                        `FCP_CMD_RESET};
      4'h3: begin
        unique case (op)
          FCP_OP_CMD_WRITE:     a.kind = FCP_ACC_WRITE;
          FCP_OP_FLASH_READ,
          FCP_OP_TOGGLE_POLL:   a.kind = FCP_ACC_READ;
          FCP_OP_SRAM_WRITE: begin
            a.kind = FCP_ACC_WRITE;
            a.sram = 1'b1;
          end
          FCP_OP_SRAM_READ: begin
            a.kind = FCP_ACC_READ;
            a.sram = 1'b1;
          end
          FCP_OP_PROTECT_CHECK: a = '{FCP_ACC_WRITE, 1'b0,
                                      `FCP_UNLOCK_ADDR1, `FCP_CMD_UNLOCK1};
          FCP_OP_RESET_SEQ,
          FCP_OP_HW_RESET:      a.kind = FCP_ACC_NONE;
        endcase
      end
      4'h4: begin
        if (op == FCP_OP_TOGGLE_POLL) begin
          a.kind = FCP_ACC_READ;
        end else if (op == FCP_OP_PROTECT_CHECK) begin
          a = '{FCP_ACC_WRITE, 1'b0, `FCP_UNLOCK_ADDR2, `FCP_CMD_UNLOCK2};
        end
      end
      4'h5: begin
        if (op == FCP_OP_PROTECT_CHECK) begin
          a = '{FCP_ACC_WRITE, 1'b0, `FCP_UNLOCK_ADDR1, `FCP_CMD_ID_ENTRY};
        end
      end
      4'h6: begin
        if (op == FCP_OP_PROTECT_CHECK) begin
          a.kind = FCP_ACC_READ;
        end
      end
      default: a.kind = FCP_ACC_NONE;
    endcase
    if (op != FCP_OP_PROTECT_CHECK && step > `FCP_STEP_CMD + 4'h1) begin
      a.kind = FCP_ACC_NONE;
    end
    return a;
  endfunction

  // Address for the data access of an accepted request, after any unlock or reset writes
  function automatic logic [`FCP_AW-1:0] fcp_req_addr(input fcp_req_s r);
    logic [`FCP_AW-1:0] a;
    a = r.addr;
    if (r.op == FCP_OP_PROTECT_CHECK) begin
      a = (r.addr & ~`FCP_ID_BITS_MASK) | `FCP_ID_BITS_PROT;
    end else if (r.op == FCP_OP_TOGGLE_POLL) begin
      unique case (r.poll_kind)
        FCP_POLL_PROGRAM,
        FCP_POLL_BLOCK_ERASE: a = r.addr;
        FCP_POLL_CHIP_ERASE:  a = '0;
        FCP_POLL_SUSPEND:     a = r.addr ^ `FCP_BLOCK_FLIP;
      endcase
    end
    return a;
  endfunction

  assign acc = fcp_access(h_reg.op, h_reg.step, h_reg.addr, h_reg.data);

  always_comb begin
    h_next           = h_reg;
    h_next.rsp_valid = 1'b0;
    unique case (h_reg.st)
      FCP_ST_IDLE: begin
        if (REQ_VALID && !lock_s) begin
          h_next.op    = REQ.op;
          h_next.addr  = fcp_req_addr(REQ);
          h_next.data  = REQ.data;
          h_next.lost  = 1'b0;
          h_next.polls = '0;
          h_next.cnt   = '0;
          h_next.rsp   = '0;
          h_next.st    = (REQ.op == FCP_OP_HW_RESET) ? FCP_ST_HWRST
                                                     : FCP_ST_NEXT;
          // Reset sequence prefixed to flash work after reset, lockout or poll timeout
          h_next.step  = ((h_reg.need_reset && REQ.op != FCP_OP_SRAM_WRITE &&
                           REQ.op != FCP_OP_SRAM_READ) ||
                          REQ.op == FCP_OP_RESET_SEQ) ? 4'h0
                                                      : `FCP_STEP_CMD;
        end
      end
      FCP_ST_NEXT: begin
        h_next.cnt = '0;
        unique case (acc.kind)
          FCP_ACC_WRITE: h_next.st = FCP_ST_WSETUP;
          FCP_ACC_READ:  h_next.st = FCP_ST_RSTROBE;
          FCP_ACC_NONE: begin
            if (h_reg.op == FCP_OP_TOGGLE_POLL &&
                (h_reg.rd_prev[`FCP_TOGGLE_BIT] !=
                 h_reg.rd_data[`FCP_TOGGLE_BIT]) &&
                h_reg.polls != `FCP_POLL_MAX) begin
              h_next.polls = h_reg.polls + 5'h01;
              h_next.step  = `FCP_STEP_CMD;
            end else begin
              h_next.st               = FCP_ST_IDLE;
              h_next.rsp_valid        = 1'b1;
              h_next.rsp.data         = h_reg.rd_data;
              h_next.rsp.is_protected = (h_reg.op == FCP_OP_PROTECT_CHECK) &&
                (h_reg.rd_data[7:0] == `FCP_PROT_CODE);
              h_next.rsp.err_timeout  = (h_reg.op == FCP_OP_TOGGLE_POLL) &&
                (h_reg.polls == `FCP_POLL_MAX);
              if (h_next.rsp.err_timeout) begin
                h_next.need_reset = 1'b1;
              end
            end
          end
          default: h_next.st = FCP_ST_IDLE;
        endcase
      end
      FCP_ST_WSETUP: h_next.st = FCP_ST_WSTROBE;
      FCP_ST_WSTROBE: begin
        h_next.cnt = h_reg.cnt + 5'h01;
        if (h_reg.cnt == `FCP_CNT_W'(`FCP_STROBE_CYC - 1)) begin
          h_next.st = FCP_ST_WHOLD;
        end
      end
      FCP_ST_WHOLD: begin
        if (h_reg.step == 4'h2 || h_reg.step == 4'h9) begin
          h_next.need_reset = 1'b0;
        end
        h_next.step = h_reg.step + 4'h1;
        h_next.st   = FCP_ST_NEXT;
      end
      FCP_ST_RSTROBE: begin
        h_next.cnt = h_reg.cnt + 5'h01;
        if (h_reg.cnt == `FCP_CNT_W'(`FCP_RD_CYC - 1)) begin
          h_next.rd_prev = h_reg.rd_data;
          h_next.rd_data = dq_s;
          h_next.cnt     = '0;
          h_next.st      = FCP_ST_TURN;
        end
      end
      FCP_ST_TURN: begin
        h_next.cnt = h_reg.cnt + 5'h01;
        if (h_reg.cnt == `FCP_CNT_W'(`FCP_TURN_CYC - 1)) begin
          h_next.step = h_reg.step + 4'h1;
          h_next.st   = FCP_ST_NEXT;
        end
      end
      FCP_ST_HWRST: begin
        h_next.cnt = h_reg.cnt + 5'h01;
        if (h_reg.cnt == `FCP_CNT_W'(`FCP_HWRST_CYC - 1)) begin
          h_next.st         = FCP_ST_IDLE;
          h_next.need_reset = 1'b0;
          h_next.rsp_valid  = 1'b1;
        end
      end
    endcase
    // Lockout drops any sequence in flight; the device will need a reset
    if (lock_s) begin
      h_next.need_reset = 1'b1;
      if (!rb_s) begin
        h_next.lost = 1'b1;
      end
      if (h_reg.st != FCP_ST_IDLE) begin
        h_next.st              = FCP_ST_IDLE;
        h_next.rsp_valid       = 1'b1;
        h_next.rsp             = '0;
        h_next.rsp.err_lockout = 1'b1;
      end
    end
  end

  // Pin levels follow the next state so every pin comes from a flip-flop
  assign acc_n = fcp_access(h_next.op, h_next.step, h_next.addr, h_next.data);

  fcp_pin_s pin_n;

  always_comb begin
    logic wcyc;
    logic cyc;
    wcyc = (h_next.st == FCP_ST_WSETUP) || (h_next.st == FCP_ST_WSTROBE) ||
           (h_next.st == FCP_ST_WHOLD);
    cyc  = wcyc || (h_next.st == FCP_ST_RSTROBE);
    pin_n.addr                = acc_n.addr;
    pin_n.dq_out              = acc_n.data;
    pin_n.dq_oe               = wcyc;
    pin_n.flash_chip_select_n = !(cyc && !acc_n.sram);
    // Selects bracket the write strobe on both edges
    pin_n.sram_select_low_n   = !(cyc && acc_n.sram);
    pin_n.sram_select_high    = cyc && acc_n.sram;
    pin_n.write_enable_n      = (h_next.st != FCP_ST_WSTROBE);
    pin_n.output_enable_n     = (h_next.st != FCP_ST_RSTROBE);
    pin_n.reset_n             = (h_next.st != FCP_ST_HWRST);
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      h_reg                         <= '0;
      h_reg.st                      <= FCP_ST_IDLE;
      h_reg.need_reset              <= 1'b1;
      // All active-low strobes idle high from reset on; sram_select_high idles low
      h_reg.pin.flash_chip_select_n <= 1'b1;
      h_reg.pin.write_enable_n      <= 1'b1;
      h_reg.pin.output_enable_n     <= 1'b1;
      h_reg.pin.sram_select_low_n   <= 1'b1;
      h_reg.pin.reset_n             <= 1'b1;
    end else begin
      h_reg     <= h_next;
      h_reg.pin <= pin_n;
    end
  end

  assign REQ_READY = (h_reg.st == FCP_ST_IDLE) && !lock_s;
  assign RSP_VALID = h_reg.rsp_valid;
  assign RSP       = h_reg.rsp;
  assign LOST_OP   = h_reg.lost;
  assign PIN       = h_reg.pin;

endmodule

/* bench/fcp_host_chk.sv */
// Port assertions for the flash/SRAM host controller.
// Assumes fcp_pkg is compiled first; attached to fcp_host by bind.
`timescale 1ns/1ps
`include "fcp_map.svh"

module fcp_host_chk
  import fcp_pkg::*;
(
  input wire logic               CLK,
  input wire logic               SRST,
  input wire logic               REQ_VALID,
  input wire logic               REQ_READY,
  input wire fcp_pkg::fcp_req_s  REQ,
  input wire logic               RSP_VALID,
  input wire fcp_pkg::fcp_rsp_s  RSP,
  input wire logic               LOST_OP,
  input wire fcp_pkg::fcp_pin_s  PIN,
  input wire logic [`FCP_DW-1:0] DQ_IN,
  input wire logic               READY_BUSY_OUT,
  input wire logic               SUPPLY_LOCKOUT_LEVEL
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  logic flash_wr_reg;
  wire  sram_sel = !PIN.sram_select_low_n && PIN.sram_select_high;
  // Marks the first flash write strobe after reset
  always_ff @(posedge CLK) begin
    if (SRST) begin
      flash_wr_reg <= 1'b0;
    end else if (!PIN.write_enable_n && !PIN.flash_chip_select_n) begin
      flash_wr_reg <= 1'b1;
    end
  end
  sequence s_we_pulse;
    !PIN.write_enable_n [*2] ##1 PIN.write_enable_n;
  endsequence
  sequence s_oe_pulse;
    !PIN.output_enable_n [*7] ##1 PIN.output_enable_n;
  endsequence
  // A lockout abort may cut a strobe short
  property p_we_width;
    disable iff (SRST || SUPPLY_LOCKOUT_LEVEL)
    $fell(PIN.write_enable_n) |-> s_we_pulse;
  endproperty
  property p_oe_width;
    disable iff (SRST || SUPPLY_LOCKOUT_LEVEL)
    $fell(PIN.output_enable_n) |-> s_oe_pulse;
  endproperty
  property p_we_in_read;
    !PIN.output_enable_n |-> PIN.write_enable_n;
  endproperty
  property p_oe_in_write;
    !PIN.write_enable_n |-> PIN.output_enable_n && PIN.dq_oe;
  endproperty
  property p_turnaround;
    $rose(PIN.output_enable_n) |-> !PIN.dq_oe [*2];
  endproperty
  property p_sram_lead;
    $fell(PIN.write_enable_n) && sram_sel |-> $past(sram_sel);
  endproperty
  property p_sram_trail;
    disable iff (SRST || SUPPLY_LOCKOUT_LEVEL)
    $rose(PIN.write_enable_n) && $past(sram_sel) |-> sram_sel;
  endproperty
  property p_lockout;
    SUPPLY_LOCKOUT_LEVEL [*6] |-> !REQ_READY;
  endproperty
  property p_lost_clear;
    REQ_VALID && REQ_READY |=> !LOST_OP;
  endproperty
  property p_prefix;
    !flash_wr_reg && !PIN.write_enable_n && !PIN.flash_chip_select_n |->
      PIN.dq_out == `FCP_CMD_UNLOCK1 && PIN.addr == `FCP_UNLOCK_ADDR1;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe width wrong");
  a_oe_width: assert property (p_oe_width)
    else $error("output enable width wrong");
  a_we_in_read: assert property (p_we_in_read)
    else $error("write strobe low during read");
  a_oe_in_write: assert property (p_oe_in_write)
    else $error("output enable low during write");
  a_turnaround: assert property (p_turnaround)
    else $error("data driven too soon after read");
  a_sram_lead: assert property (p_sram_lead)
    else $error("sram select late for write");
  a_sram_trail: assert property (p_sram_trail)
    else $error("sram select dropped early");
  a_lockout: assert property (p_lockout)
    else $error("request accepted under lockout");
  a_lost_clear: assert property (p_lost_clear)
    else $error("lost flag not cleared on take");
  a_prefix: assert property (p_prefix)
    else $error("first flash write not a reset prefix");
endmodule

bind fcp_host fcp_host_chk i_fcp_host_chk (
  .CLK(CLK), .SRST(SRST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
  .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP(RSP), .LOST_OP(LOST_OP),
  .PIN(PIN), .DQ_IN(DQ_IN), .READY_BUSY_OUT(READY_BUSY_OUT),
  .SUPPLY_LOCKOUT_LEVEL(SUPPLY_LOCKOUT_LEVEL)
);

/* bench/fcp_dev_model.sv */
// Behavioural flash/SRAM package seen from the host controller's pins.
// Assumes pins change on CLK edges; DQ has no pull, so idle shows ~last.
`timescale 1ns/1ps
`include "fcp_map.svh"

module fcp_dev_model
  import fcp_pkg::*;
#(
  parameter int BUSY_CYC = 200
) (
  input  wire logic               CLK,
  input  wire fcp_pkg::fcp_pin_s  PIN,
  input  wire logic               SUPPLY_LOCKOUT_LEVEL,
  output logic [`FCP_DW-1:0]      DQ_IN,
  output logic                    READY_BUSY_OUT
);
  logic [1:0]  step = 2'h0;
  logic        id_mode = 1'b0;
  logic        prog_arm = 1'b0;
  logic        armed = 1'b0;
  logic        stuck = 1'b0;
  logic        tog = 1'b0;
  int          busy_cnt = 0;
  logic [15:0] last = 16'h0000;
  logic [15:0] rd;
  logic [15:0] sram [16];
  fcp_pin_s    prev = '1;
  wire fsel = !PIN.flash_chip_select_n;
  wire ssel = !PIN.sram_select_low_n && PIN.sram_select_high;
  wire busy = (busy_cnt > 0) || stuck;
  // Drives only in a read with write high
  wire drv = !PIN.output_enable_n && PIN.write_enable_n && (fsel || ssel);
  wire wr_edge = PIN.write_enable_n && !prev.write_enable_n && armed;
  always_comb begin
    rd = PIN.addr[15:0] ^ {PIN.addr[20:16], 11'h000};
    if (ssel) begin
      rd = sram[PIN.addr[3:0]];
    end else if (id_mode) begin
      rd = (PIN.addr[20] && {PIN.addr[6], PIN.addr[1:0]} == 3'b010) ?
           16'h0001 : 16'h0000;
    end else if (busy) begin
      rd[6] = tog;
    end
  end
  assign DQ_IN = drv ? rd : ~last;
  assign READY_BUSY_OUT = !busy;
  always @(posedge CLK) begin
    prev <= PIN;
    armed <= armed || (PIN.write_enable_n && PIN.flash_chip_select_n);
    if (drv) begin
      last <= rd;
    end
    if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
    if (drv && fsel && prev.output_enable_n && busy) begin
      tog <= !tog;
    end
    if (!PIN.reset_n || SUPPLY_LOCKOUT_LEVEL) begin
      step <= 2'h0;
      id_mode <= 1'b0;
      prog_arm <= 1'b0;
      busy_cnt <= 0;
      stuck <= 1'b0;
    end else if (wr_edge && ssel) begin
      sram[PIN.addr[3:0]] <= PIN.dq_out;
    end else if (wr_edge && fsel && !busy) begin
      if (prog_arm) begin
        busy_cnt <= BUSY_CYC;
        // An all-ones word stands for a failed operation
        stuck <= (PIN.dq_out == 16'hffff);
        prog_arm <= 1'b0;
      end else if (step == 2'h2) begin
        id_mode <= (PIN.dq_out == 16'h0090);
        prog_arm <= (PIN.dq_out == 16'h00a0);
        step <= 2'h0;
      end else if (PIN.dq_out == (step == 2'h0 ? 16'h00aa : 16'h0055)) begin
        step <= step + 2'h1;
      end else begin
        step <= 2'h0;
      end
    end
  end
endmodule

/* bench/fcp_host_bench.sv */
// Self-checking bench: host controller against a behavioural package.
// Assumes fcp_pkg, the checker and the model are compiled first.
`timescale 1ns/1ps
`include "fcp_map.svh"

module fcp_host_bench;
  import fcp_pkg::*;
  logic               CLK = 1'b0;
  logic               SRST = 1'b1;
  logic               REQ_VALID = 1'b0;
  logic               SUPPLY_LOCKOUT_LEVEL = 1'b0;
  fcp_req_s           REQ = '0;
  logic               REQ_READY;
  logic               RSP_VALID;
  logic               LOST_OP;
  logic               READY_BUSY_OUT;
  fcp_rsp_s           RSP;
  fcp_rsp_s           got;
  fcp_pin_s           PIN;
  logic [`FCP_DW-1:0] DQ_IN;
  int                 cyc;
  int                 fail_count = 0;
  int                 n_tests = 0;

  fcp_host i_fcp_host (
    .CLK(CLK), .SRST(SRST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP(RSP), .LOST_OP(LOST_OP),
    .PIN(PIN), .DQ_IN(DQ_IN), .READY_BUSY_OUT(READY_BUSY_OUT),
    .SUPPLY_LOCKOUT_LEVEL(SUPPLY_LOCKOUT_LEVEL));
  fcp_dev_model #(.BUSY_CYC(200)) i_fcp_dev_model (
    .CLK(CLK), .PIN(PIN), .SUPPLY_LOCKOUT_LEVEL(SUPPLY_LOCKOUT_LEVEL),
    .DQ_IN(DQ_IN), .READY_BUSY_OUT(READY_BUSY_OUT));

  initial begin
    forever #20 CLK = ~CLK;
  end

  function automatic logic [15:0] cell_of(input logic [20:0] a);
    return a[15:0] ^ {a[20:16], 11'h000};
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One request, held until taken; cyc counts cycles to the answer
  task automatic run(input fcp_op_e op, input logic [20:0] a,
                     input logic [15:0] d = 16'h0000,
                     input fcp_poll_e pk = FCP_POLL_PROGRAM);
    @(posedge CLK);
    #2;
    REQ = '{op: op, poll_kind: pk, addr: a, data: d};
    REQ_VALID = 1'b1;
    cyc = 0;
    while (REQ_READY !== 1'b1 && cyc < 100) begin
      @(posedge CLK);
      #2;
      cyc++;
    end
    @(posedge CLK);
    #2;
    REQ_VALID = 1'b0;
    cyc = 0;
    while (RSP_VALID !== 1'b1 && cyc < 3000) begin
      @(posedge CLK);
      #2;
      cyc++;
    end
    got = RSP;
    check("rsp_seen", RSP_VALID, 1'b1);
  endtask

  task automatic program_word(input logic [20:0] a, input logic [15:0] d);
    run(FCP_OP_CMD_WRITE, 21'h000555, 16'h00aa);
    run(FCP_OP_CMD_WRITE, 21'h0002aa, 16'h0055);
    run(FCP_OP_CMD_WRITE, 21'h000555, 16'h00a0);
    run(FCP_OP_CMD_WRITE, a, d);
  endtask

  task automatic t_program;
    run(FCP_OP_FLASH_READ, 21'h000120);
    check("pre_cyc", cyc, 25);
    program_word(21'h000120, 16'h1234);
    run(FCP_OP_TOGGLE_POLL, 21'h000120);
    check("poll_to", got.err_timeout, 1'b0);
    check("poll_data", got.data, cell_of(21'h000120));
  endtask

  task automatic t_poll_addr;
    logic [20:0] a;
    for (int k = 0; k < 4; k++) begin
      a = (k == 2) ? 21'h000000 :
          (k == 3) ? (21'h01a5c3 ^ 21'h100000) : 21'h01a5c3;
      run(FCP_OP_TOGGLE_POLL, 21'h01a5c3, 16'h0000, fcp_poll_e'(k));
      check("poll_addr", got.data, cell_of(a));
    end
  endtask

  task automatic t_protect;
    run(FCP_OP_PROTECT_CHECK, 21'h1a0000);
    check("prot_hi", got.is_protected, 1'b1);
    check("prot_code", got.data[7:0], 8'h01);
    run(FCP_OP_PROTECT_CHECK, 21'h0a0000);
    check("prot_lo", got.is_protected, 1'b0);
    run(FCP_OP_RESET_SEQ, 21'h000000);
    check("rst_cyc", cyc, 16);
    run(FCP_OP_FLASH_READ, 21'h0a0043);
    check("array_rd", got.data, cell_of(21'h0a0043));
  endtask

  task automatic t_sram;
    run(FCP_OP_SRAM_WRITE, 21'h000005, 16'hbeef);
    run(FCP_OP_SRAM_WRITE, 21'h000006, 16'h0123);
    run(FCP_OP_SRAM_READ, 21'h000005);
    check("sram_5", got.data, 16'hbeef);
    run(FCP_OP_SRAM_READ, 21'h000006);
    check("sram_6", got.data, 16'h0123);
  endtask

  task automatic t_timeout;
    program_word(21'h000200, 16'hffff);
    run(FCP_OP_TOGGLE_POLL, 21'h000200);
    check("stuck_to", got.err_timeout, 1'b1);
    run(FCP_OP_HW_RESET, 21'h000000);
    run(FCP_OP_TOGGLE_POLL, 21'h000200);
    check("after_hw", got.err_timeout, 1'b0);
  endtask

  task automatic t_lockout;
    program_word(21'h000300, 16'h5555);
    // Lockout lands while a status poll is in flight
    fork
      run(FCP_OP_TOGGLE_POLL, 21'h000300);
      begin
        repeat (40) @(posedge CLK);
        #2;
        SUPPLY_LOCKOUT_LEVEL = 1'b1;
      end
    join
    check("lock_err", got.err_lockout, 1'b1);
    repeat (8) @(posedge CLK);
    #2;
    check("ready_lock", REQ_READY, 1'b0);
    check("lost", LOST_OP, 1'b1);
    SUPPLY_LOCKOUT_LEVEL = 1'b0;
    run(FCP_OP_TOGGLE_POLL, 21'h000300);
    check("no_restart", cyc < 100, 1'b1);
    check("abort_data", got.data, cell_of(21'h000300));
    check("lost_clr", LOST_OP, 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge CLK);
    #2;
    SRST = 1'b0;
    t_program();
    t_poll_addr();
    t_protect();
    t_sram();
    t_timeout();
    t_lockout();
    tally_and_finish();
  end

  // About 1300 cycles are expected; the limit leaves ample margin
  initial begin
    repeat (30000) @(posedge CLK);
    fail_count++;
    tally_and_finish();
  end
endmodule
